// ===== rtl/lcl_pkg.sv
// Constants and types for one programmable logic cluster of ten cells.
// Assumes every user of it writes lcl_pkg::name; nothing is imported.
package lcl_pkg;

   // -------------------------------------------------------------------
   // Cluster geometry
   // -------------------------------------------------------------------
   localparam int NCELL       = 10; // Cells in one cluster
   localparam int NDATA       = 4;  // Data inputs per cell
   localparam int LUT_W       = 16; // Truth table bits of a four-input LUT
   localparam int FIRST_CELL  = 0;  // Control cell, kept out of chains
   localparam int FB_CELL     = 1;  // Second cell, has register feedback
   localparam int HALF_CELLS  = 5;  // Cells 1..5 drive right, 6..10 left
   localparam int CHAIN_CELLS = 9;  // Chain cells per cluster (2..10)

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int SUM_LO   = 0; // Sum / count half of the table
   localparam int CARRY_LO = 8; // Carry half of the table
   localparam int CTL_CLK  = 0; // First cell data input used as clock
   localparam int CTL_ACLR = 1; // ... as asynchronous clear
   localparam int CTL_SCLR = 2; // ... as synchronous clear
   localparam int CTL_SLD  = 3; // ... as synchronous load

   // -------------------------------------------------------------------
   // Reset values and row defaults
   // -------------------------------------------------------------------
   localparam logic Q_RST      = 1'h0;
   localparam logic CAS_AND_ID = 1'h1; // Neutral value of an AND chain
   localparam int   ROW_LEN    = 22;   // Clusters in one row

   // -------------------------------------------------------------------
   // Selections
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_ARITH  = 2'h1,
      MODE_COUNT  = 2'h2
   } lcl_mode_t;

   typedef enum logic [1:0] {
      FF_D  = 2'h0,
      FF_T  = 2'h1,
      FF_JK = 2'h2,
      FF_SR = 2'h3
   } lcl_ff_t;

   typedef enum logic [1:0] {
      SRC_GLOBAL = 2'h0,
      SRC_PIN    = 2'h1,
      SRC_LOGIC  = 2'h2
   } lcl_src_t;

endpackage

// ===== rtl/lcl_cluster.sv
// One logic cluster: ten lookup-table cells with flip-flops, carry and
// cascade chains, cluster controls and two local output groups.
// Assumes all cfg_* inputs are static while running and that data, chain
// and control inputs are synchronous to mclk.
`timescale 1ns/1ns

// Functional notes
// [R1] Cluster holds ten cells, chains, controls
// [R2] Two local output groups, left and right
// [R3] First cell inputs make local controls
// [R4] Four-input LUT, any function
// [R5] Flip-flop D/T/JK/SR, selectable clock, clear
// [R6] Bypass flip-flop; output goes local and global
// [R7] Chains link cells 2 to 10 only
// [R8] Carry-in feeds LUT and next carry
// [R9] Long chains continue to same-parity cluster
// [R10] Chains never cross row middle
// [R11] Final carry leaves through the cluster
// [R12] Cascade joins by AND or De Morgan OR
// [R13] OR cascade never uses the register
// [R14] Long cascade skips clusters, not centre
// [R15] n cascaded cells give 4n inputs
// [R16] One mode per cell: normal/arith/counter
// [R17] Seven cell inputs steered by mode
// [R18] Cluster-wide clock, clears and load
// [R19] Second cell has register feedback mux
// [R20] Data inputs one/two give clock enable; code uses data input two only, none on second cell
// [R21] Normal: third LUT input is carry or third data
// [R22] Normal: LUT joins cascade-in to cascade-out
// [R23] Sync clear beats sync load
// [R24] All selections are static configuration
module lcl_cluster #(
   parameter int CLUSTER_IDX = 0,
   parameter int ROW_LEN     = lcl_pkg::ROW_LEN
) (
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic [lcl_pkg::NCELL-1:0][lcl_pkg::NDATA-1:0] cell_data,
   input  wire logic                     global_clk,
   input  wire logic                     pin_clk,
   input  wire logic                     global_clr,
   input  wire logic                     pin_clr,
   input  wire logic                     cluster_sclr,
   input  wire logic                     cluster_sload,
   input  wire logic                     carry_in,
   input  wire logic                     cascade_in,
   input  wire logic [lcl_pkg::NCELL-1:0][lcl_pkg::LUT_W-1:0] cfg_lut,
   input  wire logic [lcl_pkg::NCELL-1:0][1:0] cfg_mode,
   input  wire logic [lcl_pkg::NCELL-1:0][1:0] cfg_ff_type,
   input  wire logic [lcl_pkg::NCELL-1:0] cfg_bypass,
   input  wire logic [lcl_pkg::NCELL-1:0] cfg_lut_cin,
   input  wire logic [lcl_pkg::NCELL-1:0] cfg_cas_en,
   input  wire logic [lcl_pkg::NCELL-1:0] cfg_cas_or,
   input  wire logic [lcl_pkg::NCELL-1:0] cfg_ce_en,
   input  wire logic                     cfg_fb_carry,
   input  wire logic                     cfg_ctl_local,
   input  wire logic [1:0]               cfg_clk_src,
   input  wire logic [1:0]               cfg_clr_src,
   output logic      [lcl_pkg::NCELL-1:0] cell_out,
   output logic      [lcl_pkg::NCELL-1:0] cell_q,
   output logic      [lcl_pkg::HALF_CELLS-1:0] local_right_out,
   output logic      [lcl_pkg::HALF_CELLS-1:0] local_left_out,
   output logic      [lcl_pkg::NCELL-1:0] global_out,
   output logic                          carry_out,
   output logic                          cascade_out
);

   // -------------------------------------------------------------------
   // Chain entry at row ends and at the row middle
   // -------------------------------------------------------------------
   // Chains hop two clusters, so the first two clusters of each half
   // start fresh chains and never take the neighbour's carry or cascade.
   localparam int  MID = ROW_LEN / 2;
   // [R10] Middle breaks chains
   localparam logic CHAIN_FRESH = (CLUSTER_IDX < 2) ||
                                  (CLUSTER_IDX == MID) ||
                                  (CLUSTER_IDX == MID + 1);

   logic chain_cin;
   logic chain_cas;

   // [R9] Same-parity carry entry
   // [R14] Same-parity cascade entry
   always_comb begin
      chain_cin = CHAIN_FRESH ? 1'h0 : carry_in;
      chain_cas = CHAIN_FRESH ? lcl_pkg::CAS_AND_ID : cascade_in;
   end

   // -------------------------------------------------------------------
   // Cluster control signals
   // -------------------------------------------------------------------
   logic clk_sel;
   logic clr_sel;
   logic sclr;
   logic sload;
   logic clk_prev_reg;
   logic clk_prev_next;
   logic tick;

   // [R3] Cell one drives controls
   // [R5] Clock and clear sources
   // [R18] Cluster-wide controls
   always_comb begin
      case (lcl_pkg::lcl_src_t'(cfg_clk_src))
         lcl_pkg::SRC_GLOBAL: clk_sel = global_clk;
         lcl_pkg::SRC_PIN:    clk_sel = pin_clk;
         lcl_pkg::SRC_LOGIC:  clk_sel = cfg_ctl_local &
            cell_data[lcl_pkg::FIRST_CELL][lcl_pkg::CTL_CLK];
         default:             clk_sel = global_clk;
      endcase
      case (lcl_pkg::lcl_src_t'(cfg_clr_src))
         lcl_pkg::SRC_GLOBAL: clr_sel = global_clr;
         lcl_pkg::SRC_PIN:    clr_sel = pin_clr;
         lcl_pkg::SRC_LOGIC:  clr_sel = cfg_ctl_local &
            cell_data[lcl_pkg::FIRST_CELL][lcl_pkg::CTL_ACLR];
         default:             clr_sel = global_clr;
      endcase
      if (cfg_ctl_local) begin
         sclr  = cell_data[lcl_pkg::FIRST_CELL][lcl_pkg::CTL_SCLR];
         sload = cell_data[lcl_pkg::FIRST_CELL][lcl_pkg::CTL_SLD];
      end else begin
         sclr  = cluster_sclr;
         sload = cluster_sload;
      end
      clk_prev_next = clk_sel;
      // Cell clock is a rising edge of the source seen on mclk; the
      // source must therefore run no faster than half of mclk.
      tick = clk_sel & ~clk_prev_reg;
   end

   // Edge detector state for the selected cell clock; reset to high so
   // a source that is already high at release does not fake a tick
   always_ff @(posedge mclk) begin
      if (rst) begin
         clk_prev_reg <= 1'h1;
      end else begin
         clk_prev_reg <= clk_prev_next;
      end
   end

   // -------------------------------------------------------------------
   // Cells
   // -------------------------------------------------------------------
   logic [lcl_pkg::NCELL-1:0] cout;
   logic [lcl_pkg::NCELL-1:0] casout;
   logic [lcl_pkg::NCELL-1:0] q_reg;

   // [R1] Ten cells per cluster
   genvar gi;
   generate
      for (gi = 0; gi < lcl_pkg::NCELL; gi++) begin : g_cell
         logic [lcl_pkg::NDATA-1:0] d;
         logic                      cin;
         logic                      casin;
         logic [3:0]                idx4;
         logic [2:0]                idx3;
         logic                      lut_out;
         logic                      cas_res;
         logic                      ce;
         logic                      ff_in;
         logic                      q_next;

         // [R17] Seven inputs steered
         always_comb begin
            d = cell_data[gi];
            // [R7] First cell out of chains
            if (gi == lcl_pkg::FIRST_CELL) begin
               cin   = 1'h0;
               casin = lcl_pkg::CAS_AND_ID;
            end else if (gi == lcl_pkg::FB_CELL) begin
               // [R19] Second cell feedback mux
               cin   = cfg_fb_carry ? q_reg[gi] : chain_cin;
               casin = chain_cas;
            end else begin
               cin   = cout[gi-1];
               casin = casout[gi-1];
            end

            // [R4] Four-input table
            // [R21] Carry or third input
            idx4 = {d[3], (cfg_lut_cin[gi] ? cin : d[2]), d[1], d[0]};
            idx3 = {cin, d[1], d[0]};
            cout[gi] = 1'h0;
            // [R16] One mode per cell
            case (lcl_pkg::lcl_mode_t'(cfg_mode[gi]))
               lcl_pkg::MODE_NORMAL: begin
                  lut_out = cfg_lut[gi][idx4];
               end
               lcl_pkg::MODE_ARITH: begin
                  // [R8] Carry feeds LUT and chain
                  lut_out  = cfg_lut[gi][lcl_pkg::SUM_LO + int'(idx3)];
                  cout[gi] = cfg_lut[gi][lcl_pkg::CARRY_LO + int'(idx3)];
               end
               lcl_pkg::MODE_COUNT: begin
                  // Count uses own state, enable/up-down and carry-in
                  idx3     = {cin, d[0], q_reg[gi]};
                  lut_out  = cfg_lut[gi][lcl_pkg::SUM_LO + int'(idx3)];
                  cout[gi] = cfg_lut[gi][lcl_pkg::CARRY_LO + int'(idx3)];
               end
               default: begin
                  lut_out = cfg_lut[gi][idx4];
               end
            endcase

            // [R12] AND, or OR by inversion
            // [R15] Four more inputs per cell
            // [R22] Join LUT with cascade-in
            if (!cfg_cas_en[gi]) begin
               cas_res = lut_out;
            end else if (cfg_cas_or[gi]) begin
               cas_res = ~(~lut_out & ~casin);
            end else begin
               cas_res = lut_out & casin;
            end
            casout[gi] = cas_res;

            // [R20] Clock enable on input two
            ce = (gi != lcl_pkg::FB_CELL && cfg_ce_en[gi]) ? d[1] : 1'h1;
            ff_in = cas_res;

            // [R5] Flip-flop behaviour
            // [R18] Clear and load on all
            q_next = q_reg[gi];
            if (clr_sel) begin
               q_next = 1'h0;
            end else if (tick && ce) begin
               // [R23] Clear beats load
               if (sclr) begin
                  q_next = 1'h0;
               end else if (sload) begin
                  q_next = d[2];
               end else begin
                  case (lcl_pkg::lcl_ff_t'(cfg_ff_type[gi]))
                     lcl_pkg::FF_D:  q_next = ff_in;
                     lcl_pkg::FF_T:  q_next = q_reg[gi] ^ ff_in;
                     lcl_pkg::FF_JK: q_next = (ff_in & ~q_reg[gi]) |
                                              (~d[3] & q_reg[gi]);
                     lcl_pkg::FF_SR: q_next = ff_in | (~d[3] & q_reg[gi]);
                     default:        q_next = ff_in;
                  endcase
               end
            end

            // [R6] Bypass drives outputs
            // [R13] OR cascade stays combinational
            if (cfg_bypass[gi] || (cfg_cas_en[gi] && cfg_cas_or[gi])) begin
               cell_out[gi] = cas_res;
            end else begin
               cell_out[gi] = q_reg[gi];
            end
         end

         // Cell register
         always_ff @(posedge mclk) begin
            if (rst) begin
               q_reg[gi] <= lcl_pkg::Q_RST;
            end else begin
               q_reg[gi] <= q_next;
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // [R2] Left and right local groups
   // [R6] Local and global copies
   // [R11] Final carry leaves cluster
   // [R24] Static selections steer all
   always_comb begin
      cell_q          = q_reg;
      local_right_out = cell_out[lcl_pkg::HALF_CELLS-1:0];
      local_left_out  = cell_out[lcl_pkg::NCELL-1:lcl_pkg::HALF_CELLS];
      global_out      = cell_out;
      carry_out       = cout[lcl_pkg::NCELL-1];
      cascade_out     = casout[lcl_pkg::NCELL-1];
   end

endmodule // lcl_cluster

// ===== dv/lcl_cluster_asserts.sv
// Port checker for lcl_cluster, bound into every instance.
// Assumes one mclk domain and a synchronous active high rst.
`timescale 1ns/1ns
module lcl_cluster_chk #(
   parameter int CLUSTER_IDX = 0,
   parameter int ROW_LEN     = lcl_pkg::ROW_LEN
) (
   input wire logic                           mclk,
   input wire logic                           rst,
   input wire logic                           global_clk,
   input wire logic                           global_clr,
   input wire logic                           cluster_sclr,
   input wire logic                           cluster_sload,
   input wire logic [lcl_pkg::NCELL-1:0]      cfg_ce_en,
   input wire logic                           cfg_ctl_local,
   input wire logic [1:0]                     cfg_clk_src,
   input wire logic [1:0]                     cfg_clr_src,
   input wire logic [lcl_pkg::NCELL-1:0]      cell_out,
   input wire logic [lcl_pkg::NCELL-1:0]      cell_q,
   input wire logic [lcl_pkg::HALF_CELLS-1:0] local_right_out,
   input wire logic [lcl_pkg::HALF_CELLS-1:0] local_left_out,
   input wire logic [lcl_pkg::NCELL-1:0]      global_out
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Local control sources are not judged: their timing is the user's
   wire logic glb = cfg_clk_src == 2'h0 && cfg_clr_src == 2'h0 && !cfg_ctl_local;

   a_right_group: assert property (local_right_out == cell_out[4:0])
      else $error("right group wrong");
   a_left_group: assert property (local_left_out == cell_out[9:5])
      else $error("left group wrong");
   a_global_copy: assert property (global_out == cell_out)
      else $error("global output wrong");
   a_reset_zero: assert property ($fell(rst) |-> cell_q == '0)
      else $error("registers not zero after reset");
   a_clear_now: assert property (glb && global_clr |=> cell_q == '0)
      else $error("clear did not empty registers");
   a_clear_stays:
      assert property (glb && global_clr ##1 glb && !$rose(global_clk)
         |=> cell_q == '0) else $error("cleared registers moved");
   a_sclr_first:
      assert property (glb && !global_clr && cluster_sclr && cluster_sload
         && cfg_ce_en == '0 && $rose(global_clk) && !$past(rst)
         |=> cell_q == '0) else $error("sync clear lost to load");
   a_q_holds:
      assert property (glb && !global_clr && !$rose(global_clk)
         |=> $stable(cell_q)) else $error("registers moved without tick");
endmodule // lcl_cluster_chk

bind lcl_cluster lcl_cluster_chk #(
   .CLUSTER_IDX(CLUSTER_IDX),
   .ROW_LEN    (ROW_LEN)
) u_chk (
   .mclk, .rst, .global_clk, .global_clr, .cluster_sclr, .cluster_sload,
   .cfg_ce_en, .cfg_ctl_local, .cfg_clk_src, .cfg_clr_src, .cell_out,
   .cell_q, .local_right_out, .local_left_out, .global_out
);

// ===== dv/lcl_fabric.sv
// Far side of one cluster: clock fabric and the chain cluster behind it.
// Assumes requests change just after a rising mclk edge.
`timescale 1ns/1ns
module lcl_fabric (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic tick_req,
   input  wire logic chain_carry,
   input  wire logic chain_cas,
   output logic      global_clk,
   output logic      carry_in,
   output logic      cascade_in
);
   logic [2:0] far_reg, far_next;
   always_comb far_next = {tick_req && !far_reg[2], chain_carry, chain_cas};
   // Clock low at reset, so a stale level never fakes a first tick
   always_ff @(posedge mclk) far_reg <= rst ? 3'h0 : far_next;
   assign {global_clk, carry_in, cascade_in} = far_reg;
endmodule // lcl_fabric

// ===== dv/lcl_cluster_tb.sv
// Bench for lcl_cluster: combinational table, then registers, controls
// and chains. Assumes lcl_fabric drives clock and chain inputs.
`timescale 1ns/1ns
module lcl_cluster_tb;
   // Rows {nibble on all cells, outputs}: cell 0 true at 4 only, even
   // cells AND the nibble, odd cells OR it
   localparam logic [13:0] ROWS [4] = '{14'h12AB, 14'h3FFE, 14'h0000,
                                        14'h16AA};
   logic             mclk, rst, tick_req, chain_carry, chain_cas, global_clk;
   logic             carry_in, cascade_in, global_clr, carry_out, cascade_out;
   logic             cluster_sclr, cluster_sload, cfg_fb_carry, cfg_ctl_local;
   logic [1:0]       cfg_clk_src, cfg_clr_src;
   logic [9:0][3:0]  cell_data;
   logic [9:0][15:0] cfg_lut;
   logic [9:0][1:0]  cfg_mode, cfg_ff_type;
   logic [9:0]       cfg_bypass, cfg_lut_cin, cfg_cas_en, cfg_cas_or, cfg_ce_en;
   logic [9:0]       cell_out, cell_q, global_out;
   logic [4:0]       local_right_out, local_left_out;
   int               n_fail = 0;
   int               tests_run = 0;

   lcl_cluster #(.CLUSTER_IDX(2)) dut (
      .mclk, .rst, .cell_data, .global_clk, .pin_clk(1'b0), .global_clr,
      .pin_clr(1'b0), .cluster_sclr, .cluster_sload, .carry_in, .cascade_in,
      .cfg_lut, .cfg_mode, .cfg_ff_type, .cfg_bypass, .cfg_lut_cin,
      .cfg_cas_en, .cfg_cas_or, .cfg_ce_en, .cfg_fb_carry, .cfg_ctl_local,
      .cfg_clk_src, .cfg_clr_src, .cell_out, .cell_q, .local_right_out,
      .local_left_out, .global_out, .carry_out, .cascade_out);
   lcl_fabric u_far (.mclk, .rst, .tick_req, .chain_carry, .chain_cas,
      .global_clk, .carry_in, .cascade_in);

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Whole run is under 200 cycles; a hang is cut well after that
   initial begin
      repeat (1000) @(posedge mclk);
      n_fail++;
      complete_run();
   end

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [9:0] e, g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One far-side clock pulse, then let the register update land
   task automatic tick;
      tick_req = 1'b1;
      step(1);
      tick_req = 1'b0;
      step(2);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      {tick_req, chain_carry, chain_cas, global_clr} = 4'h0;
      {cluster_sclr, cluster_sload, cfg_fb_carry, cfg_ctl_local} = 4'h0;
      {cfg_clk_src, cfg_clr_src, cfg_mode, cfg_ff_type, cell_data} = '0;
      {cfg_lut_cin, cfg_cas_en, cfg_cas_or, cfg_ce_en} = '0;
      cfg_bypass = '1;
      for (int k = 0; k < 10; k++) cfg_lut[k] = k[0] ? 16'hFFFE : 16'h8000;
      cfg_lut[0] = 16'h0010;
      step(6);
      rst = 1'b0;
      step(1);
      chk("reset q", 10'h000, cell_q);
      foreach (ROWS[i]) begin
         cell_data = {10{ROWS[i][13:10]}};
         step(1);
         chk("cell out", ROWS[i][9:0], cell_out);
         chk("local out", ROWS[i][9:0], {local_left_out, local_right_out});
         chk("normal carry", 10'h000, {9'h000, carry_out});
      end
      // Registered path: still until a tick, then enable and sync controls
      cfg_bypass = '0;
      cell_data = {10{4'hF}};
      step(2);
      chk("held q", 10'h000, cell_q);
      tick();
      chk("ticked q", 10'h3FE, cell_q);
      cfg_ce_en = '1;
      cell_data = {10{4'h4}};
      cell_data[1] = 4'h0;
      tick();
      chk("enable low", 10'h3FC, cell_q);
      cfg_ce_en = '0;
      {cluster_sclr, cluster_sload} = 2'h3;
      tick();
      chk("sclr over sload", 10'h000, cell_q);
      {cluster_sclr, cluster_sload} = 2'h0;
      cell_data = {10{4'hF}};
      tick();
      global_clr = 1'b1;
      step(1);
      chk("clear q", 10'h000, cell_q);
      global_clr = 1'b0;
      // Counter: cells 2..10 add the held carry into their registers
      cfg_mode = {{9{2'h2}}, 2'h0};
      cfg_lut[9:1] = {9{16'hA05A}};
      chain_carry = 1'b1;
      step(2);
      repeat (3) tick();
      chk("count", 10'h006, cell_q);
      // Arithmetic ripple: sum and carry tables of a full adder
      cfg_mode = {{9{2'h1}}, 2'h0};
      cfg_lut[9:1] = {9{16'hE896}};
      cfg_bypass = '1;
      cell_data = {10{4'h1}};
      step(1);
      chk("carry ripple", 10'h200, {carry_out, cell_out[9:1]});
      chain_carry = 1'b0;
      step(2);
      chk("carry stop", 10'h1FF, {carry_out, cell_out[9:1]});
      // Cascade: AND chain, then OR chain
      cfg_mode = '0;
      cfg_lut[9:1] = {9{16'h8000}};
      cfg_cas_en = 10'h3FE;
      cell_data = {10{4'hF}};
      chain_cas = 1'b1;
      step(2);
      chk("and chain", 10'h001, {9'h000, cascade_out});
      cell_data[5] = 4'hE;
      step(1);
      chk("and chain cell", 10'h000, {9'h000, cascade_out});
      chain_cas = 1'b0;
      cfg_cas_or = 10'h3FE;
      cell_data = '0;
      step(2);
      chk("or chain", 10'h000, {9'h000, cascade_out});
      cell_data[7] = 4'hF;
      step(1);
      chk("or chain cell", 10'h001, {9'h000, cascade_out});
      // Carry-in replaces the third input of the normal-mode table
      {cfg_cas_en, cfg_cas_or} = '0;
      cfg_lut_cin = '1;
      cell_data = {10{4'hF}};
      chain_carry = 1'b1;
      step(2);
      chk("lut carry in", 10'h002, cell_out);
      cfg_lut_cin = '0;
      chain_carry = 1'b0;
      // Mid-run reset, then toggle flip-flops
      cfg_bypass = '0;
      cfg_ff_type = {10{2'h1}};
      rst = 1'b1;
      step(2);
      rst = 1'b0;
      step(1);
      chk("mid reset q", 10'h000, cell_q);
      tick();
      chk("toggle set", 10'h3FE, cell_q);
      tick();
      chk("toggle back", 10'h000, cell_q);
      // First cell inputs drive the synchronous load
      cfg_ff_type = '0;
      cfg_ctl_local = 1'b1;
      cell_data = {10{4'h4}};
      cell_data[0] = 4'h8;
      tick();
      chk("local sload", 10'h3FE, cell_q);
      cfg_ctl_local = 1'b0;
      complete_run();
   end
endmodule // lcl_cluster_tb
